// ==== hdl/mbxf_framer.v ====
// mailbox service-frame framer: parse frames, route service bodies
//
// Contract
// - 8-byte header, type 3, 2-byte command
// - command: 9 seq, 3 reserved, 4 type
// - decode message types, 0 and 9-15 reserved
// - types 2 and 3 go to service handler
// - sequence field carries process data number
// - expedited: 8-byte frame, up to 4 bytes
// - over 4 bytes: size word, extended data
// - normal payload at most capacity minus 16
// - beyond capacity: segmented, each frame headed
// - body: control, index, subindex, data, extra
// - phases 0 and 1 are init state
// - phase 2 state accepts service channel
// - safe-op: inputs valid, outputs ignored
// - op: inputs and outputs valid, applied
// - switchover checks on state transitions instead
// - accept downward transition to any lower state
// - unsupported downward transition sets error bit
`timescale 1ns/1ps
`default_nettype none
`include "mbxf_defs.vh"
module mbxf_framer #(
  parameter MBX_SIZE = 128,
  parameter DOWN_OK = 1,
  parameter FIFO_DEPTH = 16
) (
  input wire sys_clk,
  input wire resetn,
  // byte stream from the network master
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_last,
  output reg rx_ready_r,
  // service body stream to the handler
  output reg [7:0] svc_data_r,
  output reg svc_valid_r,
  output reg svc_last_r,
  input wire svc_ready,
  // frame result and service fields
  output reg svc_start_r,
  output reg [2:0] svc_mode_r,
  output reg [7:0] svc_ctrl_r,
  output reg [15:0] svc_index_r,
  output reg [7:0] svc_subidx_r,
  output reg [31:0] svc_size_r,
  output reg [3:0] msg_type_r,
  output reg [8:0] msg_seq_r,
  output reg frame_ok_r,
  output reg frame_drop_r,
  // state requests and the state view
  input wire [3:0] req_state,
  input wire req_valid,
  input wire check_ok,
  output reg [3:0] al_state_r,
  output reg al_err_r,
  output reg [2:0] phase_r,
  output reg cyc_run_r,
  output reg in_valid_r,
  output reg out_apply_r
);
  // parser phases
  localparam P_HDR = 2'h0;
  localparam P_CMD = 2'h1;
  localparam P_BODY = 2'h2;
  localparam P_DROP = 2'h3;
  // limits kept at 16 bits, cut on purpose from the integer parameter
  localparam CAP_I = MBX_SIZE;
  localparam NORM_I = MBX_SIZE - `MBXF_SVC_OVERHEAD;
  localparam [15:0] CAP = CAP_I[15:0];
  localparam [15:0] NORMAL_MAX = NORM_I[15:0];
  // transfer modes, one-hot
  localparam [2:0] M_EXP = 3'h1;
  localparam [2:0] M_NORM = 3'h2;
  localparam [2:0] M_SEG = 3'h4;
  // parser registers
  reg [1:0] ph_r;
  reg [15:0] bcnt_r;
  reg [15:0] mlen_r;
  reg [7:0] cmd_lo_r;
  reg [3:0] htype_r;
  reg svc_r;
  reg [31:0] size_r;
  // state machine view and fifo hookup
  wire [3:0] st_w;
  wire err_w;
  wire [2:0] phs_w;
  wire [8:0] f_in;
  wire f_in_ready;
  wire [8:0] f_out;
  wire f_out_valid;
  wire f_out_ready;
  wire take;
  wire reserved_type;
  wire [3:0] mt_w;
  wire mbx_on;
  wire f_in_valid;
  wire [31:0] size_w;
  // ----------------------------------------
  // slave state machine
  // ----------------------------------------
  mbxf_state #(
    .DOWN_OK(DOWN_OK)
  ) u_state (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .req_state(req_state),
    .req_valid(req_valid),
    .check_ok(check_ok),
    .state_r(st_w),
    .al_err_r(err_w),
    .phase_r(phs_w)
  );
  // ----------------------------------------
  // service data fifo
  // ----------------------------------------
  // body bytes wait here while the handler stalls
  mbxf_fifo #(
    .W(9),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_data(f_in),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready)
  );
  assign f_in = {rx_last, rx_data};
  // a byte moves on when the stage is empty or the handler takes it
  assign f_out_ready = !svc_valid_r || svc_ready;
  // body bytes of service frames enter the fifo from byte 10 on
  assign f_in_valid = take && (ph_r == P_BODY) && svc_r && (bcnt_r >= 16'h000a);
  // size word with a top byte taken in this very cycle, so a frame that
  // ends on byte 17 does not report a stale upper size byte
  assign size_w = (take && ph_r == P_BODY && bcnt_r == 16'h0011) ?
    {rx_data, size_r[23:0]} : size_r;
  // mailbox accepted from pre-op upward
  assign mbx_on = (st_w != `MBXF_ST_INIT);
  assign take = rx_valid && rx_ready_r;
  assign mt_w = rx_data[`MBXF_MTYPE_LSB-8 +: `MBXF_MTYPE_W];
  assign reserved_type = (mt_w == 4'h0) || (mt_w > `MBXF_MT_SINFO);
  // ----------------------------------------
  // receive parser
  // ----------------------------------------
  // byte map of a frame as counted by bcnt_r:
  //   0-1 length of command word plus body, little endian
  //   5 low nibble is the protocol type of the header
  //   8-9 command word: sequence low byte, then bit 0 = sequence bit 8
  //       and bits 7:4 = message type
  //   10 service control, 11-12 object index, 13 sub-index
  //   14-17 data bytes, or the total size for a normal transfer
  //   18 on: optional data bytes, then extended data
  // the header is judged on its last byte, the command word on its
  // second, so a refused frame is drained and flagged at its end
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ph_r <= P_HDR;
      bcnt_r <= 16'h0000;
      mlen_r <= 16'h0000;
      cmd_lo_r <= 8'h00;
      htype_r <= 4'h0;
      svc_r <= 1'b0;
      size_r <= 32'h00000000;
      rx_ready_r <= 1'b0;
      msg_type_r <= 4'h0;
      msg_seq_r <= 9'h000;
      frame_ok_r <= 1'b0;
      frame_drop_r <= 1'b0;
      svc_start_r <= 1'b0;
      svc_mode_r <= 3'h0;
      svc_ctrl_r <= 8'h00;
      svc_index_r <= 16'h0000;
      svc_subidx_r <= 8'h00;
      svc_size_r <= 32'h00000000;
    end else begin
      // ready is a flop and lags the fifo full flag by a cycle; pausing
      // one cycle after each fifo write keeps the flag it follows current,
      // so no byte is taken into a full fifo. body bytes of service
      // frames therefore arrive at most every other cycle
      rx_ready_r <= f_in_ready && !f_in_valid;
      frame_ok_r <= 1'b0;
      frame_drop_r <= 1'b0;
      svc_start_r <= 1'b0;
      if (take) begin
        bcnt_r <= rx_last ? 16'h0000 : bcnt_r + 16'h0001;
        case (ph_r)
          P_HDR: begin
            if (bcnt_r == `MBXF_LEN_LO_BYTE) mlen_r[7:0] <= rx_data;
            if (bcnt_r == `MBXF_LEN_HI_BYTE) mlen_r[15:8] <= rx_data;
            if (bcnt_r == `MBXF_HDR_TYPE_BYTE) htype_r <= rx_data[3:0];
            // header of 8 bytes, then command word
            if (bcnt_r == `MBXF_HDR_BYTES - 1) begin
              if (htype_r != `MBXF_PROTO_TYPE || mlen_r > CAP) begin
                ph_r <= P_DROP;
              end else begin
                ph_r <= P_CMD;
              end
            end
          end
          P_CMD: begin
            if (bcnt_r == `MBXF_HDR_BYTES) begin
              cmd_lo_r <= rx_data;
            end else begin
              if (reserved_type || !mbx_on) begin
                ph_r <= P_DROP;
              end else begin
                msg_type_r <= mt_w;
                msg_seq_r <= {rx_data[0], cmd_lo_r};
                svc_r <= (mt_w == `MBXF_MT_SREQ) || (mt_w == `MBXF_MT_SRSP);
                ph_r <= P_BODY;
              end
            end
          end
          P_BODY: begin
            // control, index, subindex, four data bytes
            case (bcnt_r)
              16'h000a: svc_ctrl_r <= rx_data;
              16'h000b: svc_index_r[7:0] <= rx_data;
              16'h000c: svc_index_r[15:8] <= rx_data;
              16'h000d: svc_subidx_r <= rx_data;
              16'h000e: size_r[7:0] <= rx_data;
              16'h000f: size_r[15:8] <= rx_data;
              16'h0010: size_r[23:16] <= rx_data;
              16'h0011: size_r[31:24] <= rx_data;
              default: size_r <= size_r;
            endcase
          end
          // drop phase: read out to the last byte, keep nothing
          default: begin
            ph_r <= P_DROP;
          end
        endcase
        // end of frame: report it and rearm the parser for a header
        if (rx_last) begin
          ph_r <= P_HDR;
          if (ph_r == P_BODY) begin
            frame_ok_r <= 1'b1;
            svc_start_r <= svc_r;
            svc_size_r <= size_w;
            // classify transfer by length
            // expedited when the body is the bare 8-byte service frame,
            // normal while the size fits the mailbox less its overhead
            if (mlen_r <= `MBXF_CMD_BYTES + `MBXF_SVC_FRAME_BYTES) begin
              svc_mode_r <= M_EXP;
            end else if (size_w <= {16'h0000, NORMAL_MAX}) begin
              svc_mode_r <= M_NORM;
            end else begin
              svc_mode_r <= M_SEG;
            end
          end else begin
            frame_drop_r <= 1'b1;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // service stream output stage
  // ----------------------------------------
  // one register stage so the stream leaves straight from flops
  always @(posedge sys_clk) begin
    if (!resetn) begin
      svc_data_r <= 8'h00;
      svc_valid_r <= 1'b0;
      svc_last_r <= 1'b0;
    end else if (f_out_ready) begin
      svc_valid_r <= f_out_valid;
      svc_data_r <= f_out[7:0];
      svc_last_r <= f_out[8];
    end
  end
  // ----------------------------------------
  // state outputs and cyclic data qualifiers
  // ----------------------------------------
  // every output here is one flop behind the state machine, and its
  // phase view is decoded without a flop, so state, phase and the
  // cyclic qualifiers all change on the same edge
  always @(posedge sys_clk) begin
    if (!resetn) begin
      al_state_r <= `MBXF_ST_INIT;
      al_err_r <= 1'b0;
      phase_r <= 3'h0;
      cyc_run_r <= 1'b0;
      in_valid_r <= 1'b0;
      out_apply_r <= 1'b0;
    end else begin
      al_state_r <= st_w;
      al_err_r <= err_w;
      phase_r <= phs_w;
      cyc_run_r <= (st_w == `MBXF_ST_SAFEOP) || (st_w == `MBXF_ST_OP);
      in_valid_r <= (st_w == `MBXF_ST_SAFEOP) || (st_w == `MBXF_ST_OP);
      out_apply_r <= (st_w == `MBXF_ST_OP);
    end
  end
endmodule
`default_nettype wire

// ==== include/mbxf_defs.vh ====
// constants for the mailbox service-frame framer
`ifndef MBXF_DEFS_VH
`define MBXF_DEFS_VH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define MBXF_HDR_BYTES 8
`define MBXF_CMD_BYTES 2
`define MBXF_MAX_PAYLOAD 1478
`define MBXF_HDR_TYPE_BYTE 5
`define MBXF_PROTO_TYPE 4'h3
`define MBXF_LEN_LO_BYTE 0
`define MBXF_LEN_HI_BYTE 1
`define MBXF_SEQ_LSB 0
`define MBXF_SEQ_W 9
`define MBXF_MTYPE_LSB 12
`define MBXF_MTYPE_W 4
`define MBXF_SVC_OVERHEAD 16
`define MBXF_EXP_MAX 4
`define MBXF_SVC_FRAME_BYTES 8
// ----------------------------------------
// message types
// ----------------------------------------
`define MBXF_MT_EMCY 4'h1
`define MBXF_MT_SREQ 4'h2
`define MBXF_MT_SRSP 4'h3
`define MBXF_MT_TXPD 4'h4
`define MBXF_MT_RXPD 4'h5
`define MBXF_MT_RTXR 4'h6
`define MBXF_MT_RRXR 4'h7
`define MBXF_MT_SINFO 4'h8
// ----------------------------------------
// slave states
// ----------------------------------------
`define MBXF_ST_INIT 4'h1
`define MBXF_ST_PREOP 4'h2
`define MBXF_ST_SAFEOP 4'h4
`define MBXF_ST_OP 4'h8
`endif

// ==== hdl/mbxf_fifo.v ====
// parameterised valid/ready fifo for mailbox bytes
`timescale 1ns/1ps
`default_nettype none
module mbxf_fifo #(
  parameter W = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire do_wr;
  wire do_rd;
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  // write side
  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // pointer and count update
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/mbxf_state.v ====
// slave state machine with servo phase mapping
`timescale 1ns/1ps
`default_nettype none
`include "mbxf_defs.vh"
module mbxf_state #(
  parameter DOWN_OK = 1
) (
  input wire sys_clk,
  input wire resetn,
  input wire [3:0] req_state,
  input wire req_valid,
  input wire check_ok,
  output reg [3:0] state_r,
  output reg al_err_r,
  output reg [2:0] phase_r
);
  localparam S_INIT = `MBXF_ST_INIT;
  localparam S_PREOP = `MBXF_ST_PREOP;
  localparam S_SAFEOP = `MBXF_ST_SAFEOP;
  localparam S_OP = `MBXF_ST_OP;
  wire down;
  wire up_one;
  assign down = (req_state < state_r);
  assign up_one = (req_state == {state_r[2:0], 1'b0});
  // ----------------------------------------
  // state transitions
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= S_INIT;
      al_err_r <= 1'b0;
    end else if (req_valid) begin
      case (req_state)
        S_INIT, S_PREOP, S_SAFEOP, S_OP: begin
          if (down) begin
            if (DOWN_OK != 0 || req_state == S_INIT) begin
              state_r <= req_state;
              al_err_r <= 1'b0;
            end else begin
              al_err_r <= 1'b1;
            end
          end else if (up_one) begin
            // switchover checks run on preop->safeop and safeop->op
            if ((req_state == S_SAFEOP || req_state == S_OP) && !check_ok) begin
              al_err_r <= 1'b1;
            end else begin
              state_r <= req_state;
              al_err_r <= 1'b0;
            end
          end else if (req_state != state_r) begin
            al_err_r <= 1'b1;
          end
        end
        default: begin
          al_err_r <= 1'b1;
        end
      endcase
    end
  end
  // legacy phase view: phases 0/1 fold into init
  // decoded without a flop so the phase moves on the same edge as the state
  always @* begin
    case (state_r)
      S_PREOP: phase_r = 3'h2;
      S_SAFEOP: phase_r = 3'h3;
      S_OP: phase_r = 3'h4;
      default: phase_r = 3'h0;
    endcase
  end
endmodule
`default_nettype wire

// ==== dv/mbxf_framer_asserts.sv ====
// concurrent checks on the framer ports
`timescale 1ns/1ps
`default_nettype none
`include "mbxf_defs.vh"
module mbxf_framer_asserts (
  input wire sys_clk,
  input wire resetn,
  input wire [3:0] req_state,
  input wire req_valid,
  input wire check_ok,
  input wire svc_ready,
  input wire [7:0] svc_data_r,
  input wire svc_valid_r,
  input wire svc_start_r,
  input wire [2:0] svc_mode_r,
  input wire [3:0] msg_type_r,
  input wire frame_ok_r,
  input wire frame_drop_r,
  input wire [3:0] al_state_r,
  input wire al_err_r,
  input wire [2:0] phase_r,
  input wire in_valid_r,
  input wire out_apply_r
);
  // ------------------------------
  // frame and state relations
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ok_drop_excl_a: assert property (!(frame_ok_r && frame_drop_r))
    else $error("frame both accepted and dropped");
  svc_route_a: assert property (svc_start_r |-> ##1 (msg_type_r == `MBXF_MT_SREQ ||
    msg_type_r == `MBXF_MT_SRSP)) else $error("service start on non-service type");
  type_valid_a: assert property (frame_ok_r |-> ##1 (msg_type_r != 4'h0 &&
    msg_type_r <= 4'h8)) else $error("reserved type accepted");
  mode_onehot_a: assert property (svc_start_r |-> ##1 $onehot(svc_mode_r))
    else $error("transfer mode not one-hot");
  stream_hold_a: assert property (svc_valid_r && !svc_ready |=>
    svc_valid_r && $stable(svc_data_r)) else $error("stream byte not held");
  phase_init_a: assert property (al_state_r == `MBXF_ST_INIT |-> phase_r == 3'h0)
    else $error("init state phase wrong");
  phase_safe_a: assert property (al_state_r == `MBXF_ST_SAFEOP |->
    phase_r == 3'h3 && in_valid_r && !out_apply_r) else $error("safe-op outputs wrong");
  phase_op_a: assert property (al_state_r == `MBXF_ST_OP |->
    phase_r == 3'h4 && in_valid_r && out_apply_r) else $error("op outputs wrong");
  init_refuse_a: assert property (frame_ok_r |-> al_state_r != `MBXF_ST_INIT)
    else $error("frame accepted in init");
  down_move_a: assert property (req_valid && req_state != 4'h0 && req_state < al_state_r
    |-> ##2 al_state_r == $past(req_state, 2)) else $error("downward move not taken");
  check_gate_a: assert property (req_valid && !check_ok && req_state == `MBXF_ST_SAFEOP &&
    al_state_r == `MBXF_ST_PREOP |-> ##2 al_state_r == `MBXF_ST_PREOP && al_err_r)
    else $error("failed check still moved");
endmodule
bind mbxf_framer mbxf_framer_asserts mbxf_framer_asserts_inst (.sys_clk, .resetn,
  .req_state, .req_valid, .check_ok, .svc_ready, .svc_data_r, .svc_valid_r, .svc_start_r,
  .svc_mode_r, .msg_type_r, .frame_ok_r, .frame_drop_r, .al_state_r, .al_err_r, .phase_r,
  .in_valid_r, .out_apply_r);
`default_nettype wire

// ==== dv/mbxf_master.sv ====
// network master model that writes mailbox frames byte by byte
`timescale 1ns/1ps
`default_nettype none
module mbxf_master (
  input wire sys_clk,
  input wire rx_ready_r,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  end
  // one frame: header, command word, service body; held until taken
  task send_frame(input [3:0] ht, input [15:0] len, input [3:0] mt, input [8:0] sq,
    input [31:0] sz);
    int i;
    logic [7:0] b;
    for (i = 0; i < len + 8; i++) begin
      case (i)
        0: b = len[7:0];
        1: b = len[15:8];
        5: b = {4'h0, ht};
        8: b = sq[7:0];
        9: b = {mt, 3'h0, sq[8]};
        10: b = 8'h2f;
        12: b = 8'h60;
        13: b = 8'h01;
        14, 15, 16, 17: b = sz[8*(i-14) +: 8];
        default: b = (i < 12) ? 8'h00 : i[7:0];
      endcase
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data = b;
      rx_last = (i == len + 7);
      @(posedge sys_clk);
      while (!rx_ready_r) @(posedge sys_clk);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data; // released line does not keep its value
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the mailbox framer
`timescale 1ns/1ps
`default_nettype none
`include "mbxf_defs.vh"
module testbench;
  logic sys_clk, resetn, svc_ready, req_valid, check_ok;
  logic [3:0] req_state;
  logic [8:0] seq;
  wire [7:0] rx_data, svc_data_r, svc_ctrl_r, svc_subidx_r;
  wire rx_valid, rx_last, rx_ready_r, svc_valid_r, svc_last_r, svc_start_r, frame_ok_r;
  wire frame_drop_r, al_err_r, cyc_run_r, in_valid_r, out_apply_r;
  wire [2:0] svc_mode_r, phase_r;
  wire [15:0] svc_index_r;
  wire [31:0] svc_size_r;
  wire [3:0] msg_type_r, al_state_r;
  wire [8:0] msg_seq_r;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  int ok_n = 0, drop_n = 0, start_n = 0, byte_n = 0, last_n = 0;
  mbxf_framer mbxf_framer_inst (.sys_clk, .resetn, .rx_data, .rx_valid, .rx_last,
    .rx_ready_r, .svc_data_r, .svc_valid_r, .svc_last_r, .svc_ready, .svc_start_r,
    .svc_mode_r, .svc_ctrl_r, .svc_index_r, .svc_subidx_r, .svc_size_r, .msg_type_r,
    .msg_seq_r, .frame_ok_r, .frame_drop_r, .req_state, .req_valid, .check_ok, .al_state_r,
    .al_err_r, .phase_r, .cyc_run_r, .in_valid_r, .out_apply_r);
  mbxf_master mbxf_master_inst (.sys_clk, .rx_ready_r, .rx_data, .rx_valid, .rx_last);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // consumer stalls three cycles of every eight
  always @(negedge sys_clk) svc_ready <= (cyc % 8) > 2;
  // event counters and hang limit
  always @(posedge sys_clk) begin
    cyc++;
    ok_n += frame_ok_r;
    drop_n += frame_drop_r;
    start_n += svc_start_r;
    if (svc_valid_r && svc_ready) byte_n++;
    if (svc_valid_r && svc_ready && svc_last_r) last_n++;
    if (cyc == 30000) begin
      fail_count++;
      complete_run;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task frame(input [3:0] ht, input [15:0] len, input [3:0] mt, input [31:0] sz, input ok);
    int k, o, d, s, b, l;
    logic sv;
    o = ok_n; d = drop_n; s = start_n; b = byte_n; l = last_n;
    sv = ok && (mt == `MBXF_MT_SREQ || mt == `MBXF_MT_SRSP);
    mbxf_master_inst.send_frame(ht, len, mt, seq, sz);
    for (k = 0; k < 300; k++) begin
      @(posedge sys_clk);
      if (ok_n + drop_n != o + d && (!sv || last_n != l)) break;
    end
    repeat (20) @(posedge sys_clk);
    chk(ok_n - o, ok);
    chk(drop_n - d, !ok);
    chk(start_n - s, sv);
    if (sv) chk(byte_n - b, len - 2);
    if (ok) chk(msg_seq_r, seq);
    if (ok) chk(msg_type_r, mt);
    seq++;
  endtask
  task go(input [3:0] st, input ck, input [3:0] es, input [2:0] ep, input [2:0] eio, input er);
    @(negedge sys_clk);
    req_state = st; req_valid = 1'b1; check_ok = ck;
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(al_state_r, es);
    chk(phase_r, ep);
    chk({cyc_run_r, in_valid_r, out_apply_r}, eio);
    chk(al_err_r, er);
  endtask
  task t_init;
    chk(al_state_r, `MBXF_ST_INIT);
    frame(4'h3, 16'd10, `MBXF_MT_SREQ, 32'h4, 1'b0);
    go(`MBXF_ST_SAFEOP, 1'b1, `MBXF_ST_INIT, 3'h0, 3'h0, 1'b1);
    go(`MBXF_ST_PREOP, 1'b1, `MBXF_ST_PREOP, 3'h2, 3'h0, 1'b0);
  endtask
  task t_modes;
    frame(4'h3, 16'd10, `MBXF_MT_SREQ, 32'h4, 1'b1);
    chk(svc_mode_r, 3'h1);
    chk({svc_ctrl_r, svc_index_r, svc_subidx_r}, 32'h2f600001);
    chk(svc_size_r, 32'h4);
    frame(4'h3, 16'd40, `MBXF_MT_SRSP, 32'd30, 1'b1);
    chk(svc_mode_r, 3'h2);
    frame(4'h3, 16'd40, `MBXF_MT_SREQ, 32'd112, 1'b1);
    chk(svc_mode_r, 3'h2);
    frame(4'h3, 16'd128, `MBXF_MT_SREQ, 32'd113, 1'b1);
    chk(svc_mode_r, 3'h4);
    frame(4'h3, 16'd129, `MBXF_MT_SREQ, 32'd200, 1'b0);
  endtask
  task t_types;
    int m;
    for (m = 0; m < 16; m++) frame(4'h3, 16'd10, m[3:0], 32'h4, m >= 1 && m <= 8);
    frame(4'h4, 16'd10, `MBXF_MT_SREQ, 32'h4, 1'b0);
  endtask
  task t_states;
    go(`MBXF_ST_SAFEOP, 1'b0, `MBXF_ST_PREOP, 3'h2, 3'h0, 1'b1);
    go(`MBXF_ST_SAFEOP, 1'b1, `MBXF_ST_SAFEOP, 3'h3, 3'h6, 1'b0);
    go(`MBXF_ST_OP, 1'b1, `MBXF_ST_OP, 3'h4, 3'h7, 1'b0);
    go(`MBXF_ST_SAFEOP, 1'b1, `MBXF_ST_SAFEOP, 3'h3, 3'h6, 1'b0);
    go(`MBXF_ST_PREOP, 1'b1, `MBXF_ST_PREOP, 3'h2, 3'h0, 1'b0);
    go(`MBXF_ST_INIT, 1'b1, `MBXF_ST_INIT, 3'h0, 3'h0, 1'b0);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    resetn = 1'b0; req_valid = 1'b0; check_ok = 1'b0;
    req_state = 4'h1; seq = 9'h1fe;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_init;
    t_modes;
    t_types;
    t_states;
    complete_run;
  end
endmodule
`default_nettype wire
